/* File: rtl/scc_cfg.svh */
// Purpose: constants for the converter control block
// Assumes: included by its bare name
// Notes: codes marked as chosen here are listed for the bench
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// result width and byte layout
`define SCC_RES_W 10
`define SCC_LEFT_PAD 6
// converter clock cycles per conversion
`define SCC_NORMAL_TICKS 13
`define SCC_FIRST_TICKS 25
// trigger select code meaning "completion flag" (free running)
`define SCC_TRIG_FREE 3'h0
// channel codes at or above this are differential pairs
`define SCC_DIFF_BASE 5'h08
// reset values
`define SCC_SEL_RST 7'h00
`define SCC_BYTE_RST 8'h00

`endif

/* File: rtl/scc_pkg.sv */
// Purpose: types shared by the converter control block
// Assumes: nothing
// Notes: constants live in scc_cfg.svh
`default_nettype none
package scc_pkg;
    // sequencer phases
    typedef enum logic [1:0] {
        IDLE,
        WAIT_TICK,
        CONVERT
    } scc_state_t;

    // selection handed to the analog side
    typedef struct packed {
        logic [1:0] reference;
        logic [4:0] channel;
    } scc_sel_t;

    // the two readable data bytes
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } scc_bytes_t;
endpackage
`default_nettype wire

/* File: rtl/scc_converter_control.sv */
// Purpose: control for a 10-bit successive-approximation converter
// Assumes: all inputs synchronous to clk; read strobes are one-cycle
// Notes: prescaler ratio is a parameter; no register bus
//
// Contract
// - zero is ground, top is ref minus LSB
// - reference choice applied from reference select bits
// - channel and gain taken from channel select field
// - differential uses gain; single-ended bypasses amplifier
// - selections applied only once converter is enabled
// - result right-justified, or left when adjust set
// - low byte read locks data; completions discarded
// - high byte read unlocks data byte updates
// - completion flag sets even when result discarded
// - start bit begins conversion, clears at end
// - channel change waits for running conversion end
// - auto-trigger enable starts conversions from selected trigger
// - trigger rising edge resets prescaler, starts conversion
// - trigger level held high starts nothing new
// - trigger edge during conversion ignored, not queued
// - trigger flag must be cleared before retriggering
// - completion-flag trigger restarts regardless of clearing
// - start bit works and reads one during conversion
// - thirteen converter cycles; first after enable twenty-five
// - at end: store result, set flag, clear start
// - prescaler runs only while enabled
`default_nettype none
`include "scc_cfg.svh"

module scc_converter_control #(
    parameter int PRESCALE_DIV = 2,
    parameter int TRIG_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic converterEnable,
    input wire logic startWrite,
    input wire logic autoTriggerEnable,
    input wire logic [2:0] triggerSourceSelect,
    input wire logic [TRIG_W-1:0] triggerIn,
    input wire logic leftAdjustResult,
    input wire scc_pkg::scc_sel_t selectWrite,
    input wire logic lowByteRead,
    input wire logic highByteRead,
    input wire logic flagClear,
    input wire logic completionIrqEnable,
    input wire logic globalIrqEnable,
    input wire logic compareIn,
    output logic startConversion,
    output logic conversionCompleteFlag,
    output logic irqRequest,
    output scc_pkg::scc_bytes_t resultBytes,
    output scc_pkg::scc_sel_t appliedSel,
    output logic gainBypass,
    output logic coreEnable,
    output logic sampleHold,
    output logic [`SCC_RES_W-1:0] sarDac
);

    localparam int PW = (PRESCALE_DIV > 1) ? $clog2(PRESCALE_DIV) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE_DIV - 1);
    localparam logic [4:0] NORMAL_LAST = 5'(`SCC_NORMAL_TICKS - 1);
    localparam logic [4:0] FIRST_LAST = 5'(`SCC_FIRST_TICKS - 1);
    localparam logic [4:0] NORMAL_SAMPLE = 5'(`SCC_NORMAL_TICKS - 12);
    localparam logic [4:0] FIRST_SAMPLE = 5'(`SCC_FIRST_TICKS - 12);

    scc_pkg::scc_state_t state;
    logic [PW-1:0] preCount;
    logic [4:0] tickCount;
    logic firstConv;
    logic enablePrev;
    logic trigPrev;
    logic locked;
    logic [`SCC_RES_W-1:0] sarMask;
    logic [`SCC_RES_W-1:0] result;
    logic preTick;
    logic trigNow;
    logic trigEdge;
    logic freeRun;
    logic autoStart;
    logic swStart;
    logic lastTick;
    logic sampleTick;
    logic finishing;
    logic restart;
    logic [`SCC_RES_W-1:0] finalCode;
    logic [`SCC_RES_W-1:0] next_dac;
    logic [`SCC_RES_W-1:0] next_mask;
    logic storeNow;
    logic [`SCC_RES_W-1:0] shownCode;

    // selected trigger and its edge against last cycle's sample
    assign trigNow = triggerIn[triggerSourceSelect];
    assign freeRun = (triggerSourceSelect == `SCC_TRIG_FREE);
    assign trigEdge = trigNow & ~trigPrev;
    // level alone never starts; edges while busy are dropped, and the
    // waiting phase counts as busy so a late edge cannot stretch the wait
    assign autoStart = converterEnable && autoTriggerEnable && !freeRun
        && trigEdge && (state == scc_pkg::IDLE);
    assign swStart = converterEnable && startWrite
        && (state == scc_pkg::IDLE);
    assign preTick = (preCount == PRE_LAST);
    assign lastTick = preTick
        && (tickCount == (firstConv ? FIRST_LAST : NORMAL_LAST));
    assign sampleTick = preTick
        && (tickCount == (firstConv ? FIRST_SAMPLE : NORMAL_SAMPLE));
    assign finishing = (state == scc_pkg::CONVERT) && lastTick
        && converterEnable;
    // completion flag as trigger: restart whatever the flag shows
    assign restart = finishing && autoTriggerEnable && freeRun;

    // trigger history runs even while disabled: a level that is already
    // high when the converter is enabled is not a fresh edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            trigPrev <= 1'b0;
        else
            trigPrev <= trigNow;
    end

    // prescaler held in reset while disabled, restarted by a trigger
    always_ff @(posedge clk)
    begin
        if (!rst_n || !converterEnable)
            preCount <= '0;
        else if (autoStart)
            preCount <= '0;
        else if (preTick)
            preCount <= '0;
        else
            preCount <= preCount + 1'b1;
    end

    // first conversion after enable runs long for analog warm-up
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            enablePrev <= 1'b0;
            firstConv <= 1'b1;
        end
        else
        begin
            enablePrev <= converterEnable;
            if (converterEnable && !enablePrev)
                firstConv <= 1'b1;
            else if (finishing)
                firstConv <= 1'b0;
        end
    end

    // sequencer: start waits for the next converter clock edge
    always_ff @(posedge clk)
    begin
        if (!rst_n || !converterEnable)
        begin
            state <= scc_pkg::IDLE;
            tickCount <= '0;
        end
        else
        begin
            unique case (state)
                scc_pkg::IDLE:
                begin
                    tickCount <= '0;
                    if (swStart || autoStart)
                        state <= scc_pkg::WAIT_TICK;
                end
                scc_pkg::WAIT_TICK:
                begin
                    tickCount <= '0;
                    // no trigger edge is taken here; the next tick begins
                    if (preTick)
                        state <= scc_pkg::CONVERT;
                end
                scc_pkg::CONVERT:
                begin
                    if (lastTick)
                    begin
                        tickCount <= '0;
                        // free running goes straight on
                        state <= restart ? scc_pkg::CONVERT
                                         : scc_pkg::IDLE;
                    end
                    else if (preTick)
                        tickCount <= tickCount + 1'b1;
                end
            endcase
        end
    end

    // start bit mirrors activity; the final cycle clears it
    always_ff @(posedge clk)
    begin
        if (!rst_n || !converterEnable)
            startConversion <= 1'b0;
        else if (swStart || autoStart)
            startConversion <= 1'b1;
        else if (finishing)
            startConversion <= restart;
    end

    // successive approximation: trial bit kept if input is at or above it
    always_comb
    begin
        next_dac = sarDac;
        next_mask = sarMask;
        if (sampleTick)
        begin
            next_dac = {1'b1, {(`SCC_RES_W-1){1'b0}}};
            next_mask = {1'b1, {(`SCC_RES_W-1){1'b0}}};
        end
        else if (preTick && (sarMask != '0))
        begin
            if (!compareIn)
                next_dac = sarDac & ~sarMask;
            next_dac = next_dac | (sarMask >> 1);
            next_mask = sarMask >> 1;
        end
    end

    // last decision lands one tick before completion, so next_dac equals sarDac
    assign finalCode = next_dac;

    // a low byte read in the finishing cycle locks as well, since that
    // read saw the old bytes; a same-cycle high byte read unlocks
    assign storeNow = finishing && !locked
        && !(lowByteRead && !highByteRead);
    // bytes are formatted from the code being stored in the same edge,
    // so a read can never pair an old low byte with a new high byte
    assign shownCode = storeNow ? finalCode : result;

    always_ff @(posedge clk)
    begin
        if (!rst_n || (state != scc_pkg::CONVERT))
        begin
            sarDac <= '0;
            sarMask <= '0;
            sampleHold <= 1'b0;
        end
        else
        begin
            sarDac <= next_dac;
            sarMask <= next_mask;
            sampleHold <= sampleTick;
        end
    end

    // data lock between low and high byte reads
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            locked <= 1'b0;
        else if (highByteRead)
            locked <= 1'b0;
        else if (lowByteRead)
            locked <= 1'b1;
    end

    // a locked completion is discarded, not deferred
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            result <= '0;
        else if (storeNow)
            result <= finalCode;
    end

    // byte layout follows the adjust bit at all times
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            resultBytes.high <= `SCC_BYTE_RST;
            resultBytes.low <= `SCC_BYTE_RST;
        end
        else if (leftAdjustResult)
        begin
            resultBytes.high <= shownCode[9:2];
            resultBytes.low <= {shownCode[1:0], {`SCC_LEFT_PAD{1'b0}}};
        end
        else
        begin
            resultBytes.high <= {{`SCC_LEFT_PAD{1'b0}}, shownCode[9:8]};
            resultBytes.low <= shownCode[7:0];
        end
    end

    // completion flag: set wins over a same-cycle clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            conversionCompleteFlag <= 1'b0;
        else if (finishing)
            conversionCompleteFlag <= 1'b1;
        else if (flagClear)
            conversionCompleteFlag <= 1'b0;
    end

    // interrupt request, registered one cycle behind the flag
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irqRequest <= 1'b0;
        else
            irqRequest <= conversionCompleteFlag && completionIrqEnable
                && globalIrqEnable;
    end

    // selection tracks software only while enabled and not mid-conversion;
    // it reopens in the final converter clock cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            appliedSel <= `SCC_SEL_RST;
            gainBypass <= 1'b1;
        end
        else if (converterEnable && ((state != scc_pkg::CONVERT)
            || (tickCount == (firstConv ? FIRST_LAST : NORMAL_LAST))))
        begin
            appliedSel <= selectWrite;
            gainBypass <= (selectWrite.channel < `SCC_DIFF_BASE);
        end
    end

    // analog core powered only while enabled, saving power when disabled
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            coreEnable <= 1'b0;
        else
            coreEnable <= converterEnable;
    end

endmodule // scc_converter_control
`default_nettype wire

/* File: dv/scc_core_model.sv */
// Purpose: ideal comparator standing in for the analog core
// Assumes: level is the bench's held analog input, in codes
// Notes: no noise, so every conversion result is exact
`default_nettype none
`include "scc_cfg.svh"
module scc_core_model (
    input wire logic [`SCC_RES_W-1:0] sarDac,
    input wire logic [`SCC_RES_W-1:0] level,
    output logic compareIn
);
    timeunit 1ns;
    timeprecision 100ps;
    // code zero is ground; full scale is one step under reference
    assign compareIn = (level >= sarDac);
endmodule // scc_core_model
`default_nettype wire

/* File: dv/scc_chk.sv */
// Purpose: port checks for the converter control block
// Assumes: one clock, synchronous active-low reset
// Notes: trigger inputs held low during reset
`default_nettype none
`include "scc_cfg.svh"
module scc_chk #(
    parameter int TRIG_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic converterEnable,
    input wire logic startWrite,
    input wire logic autoTriggerEnable,
    input wire logic [2:0] triggerSourceSelect,
    input wire logic [TRIG_W-1:0] triggerIn,
    input wire logic completionIrqEnable,
    input wire logic globalIrqEnable,
    input wire logic startConversion,
    input wire logic conversionCompleteFlag,
    input wire logic irqRequest,
    input wire scc_pkg::scc_sel_t appliedSel,
    input wire logic gainBypass,
    input wire logic sampleHold,
    input wire logic coreEnable
);
    timeunit 1ns;
    timeprecision 100ps;
    // selected trigger level
    wire logic trigSel = triggerIn[triggerSourceSelect];
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_start_taken: assert property (
        startWrite && converterEnable && !startConversion |=> startConversion)
        else $error("start request not taken");
    a_end_flag: assert property (
        $fell(startConversion) && converterEnable && $past(converterEnable)
        |-> conversionCompleteFlag)
        else $error("conversion ended without flag");
    a_irq_gate: assert property (
        irqRequest == $past(conversionCompleteFlag && completionIrqEnable
        && globalIrqEnable))
        else $error("interrupt request mismatch");
    a_core_follows: assert property (
        coreEnable == $past(converterEnable))
        else $error("core enable mismatch");
    a_disabled_idle: assert property (
        !converterEnable |=> !startConversion && $stable(appliedSel))
        else $error("activity while disabled");
    a_gain_bypass: assert property (
        $stable(appliedSel)
        |-> gainBypass == (appliedSel.channel < `SCC_DIFF_BASE))
        else $error("gain bypass mismatch");
    a_free_hold: assert property (
        autoTriggerEnable && triggerSourceSelect == `SCC_TRIG_FREE
        && converterEnable && $past(converterEnable)
        && $past(startConversion) |-> startConversion)
        else $error("free run stopped");
    // four high samples rule out a pending edge, even with a lag
    a_level_quiet: assert property (
        autoTriggerEnable && triggerSourceSelect != `SCC_TRIG_FREE && trigSel
        && $past(trigSel) && $past(trigSel, 2) && $past(trigSel, 3)
        && !startConversion && !$past(startConversion) && !startWrite
        |=> !startConversion)
        else $error("start from trigger level");
    // one sample per conversion, taken while the start bit is high
    a_sample_pulse: assert property (
        sampleHold && coreEnable |-> startConversion ##1 !sampleHold)
        else $error("sample pulse misplaced");
    c_done: cover property ($fell(startConversion));
    c_irq: cover property (irqRequest);
    c_free: cover property (autoTriggerEnable && startConversion
        && triggerSourceSelect == `SCC_TRIG_FREE);
endmodule // scc_chk
bind scc_converter_control scc_chk #(.TRIG_W(TRIG_W)) chk (
    .clk(clk), .rst_n(rst_n), .converterEnable(converterEnable),
    .startWrite(startWrite), .autoTriggerEnable(autoTriggerEnable),
    .triggerSourceSelect(triggerSourceSelect), .triggerIn(triggerIn),
    .completionIrqEnable(completionIrqEnable),
    .globalIrqEnable(globalIrqEnable), .startConversion(startConversion),
    .conversionCompleteFlag(conversionCompleteFlag),
    .irqRequest(irqRequest), .appliedSel(appliedSel),
    .gainBypass(gainBypass), .coreEnable(coreEnable),
    .sampleHold(sampleHold));
`default_nettype wire

/* File: dv/testbench.sv */
// Purpose: directed tests of the converter control block
// Assumes: prescaler divide of one so conversion lengths are exact
// Notes: inputs change 1 ns after each rising edge
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_n = 1'b0, converterEnable = 1'b0;
    logic startWrite = 1'b0, autoTriggerEnable = 1'b0, leftAdjustResult = 1'b0;
    logic lowByteRead = 1'b0, highByteRead = 1'b0, flagClear = 1'b0;
    logic completionIrqEnable = 1'b0, globalIrqEnable = 1'b0, compareIn;
    logic startConversion, conversionCompleteFlag, irqRequest, gainBypass;
    logic coreEnable, sampleHold;
    logic [2:0] triggerSourceSelect = 3'h0;
    logic [7:0] triggerIn = 8'h00;
    logic [9:0] level = 10'h000, sarDac;
    scc_pkg::scc_sel_t selectWrite = 7'h00, appliedSel;
    scc_pkg::scc_bytes_t resultBytes;
    int errors = 0, n_compared = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    scc_converter_control #(.PRESCALE_DIV(1), .TRIG_W(8)) dut (
        .clk(clk), .rst_n(rst_n), .converterEnable(converterEnable),
        .startWrite(startWrite), .autoTriggerEnable(autoTriggerEnable),
        .triggerSourceSelect(triggerSourceSelect), .triggerIn(triggerIn),
        .leftAdjustResult(leftAdjustResult), .selectWrite(selectWrite),
        .lowByteRead(lowByteRead), .highByteRead(highByteRead),
        .flagClear(flagClear), .completionIrqEnable(completionIrqEnable),
        .globalIrqEnable(globalIrqEnable), .compareIn(compareIn),
        .startConversion(startConversion),
        .conversionCompleteFlag(conversionCompleteFlag),
        .irqRequest(irqRequest), .resultBytes(resultBytes),
        .appliedSel(appliedSel), .gainBypass(gainBypass),
        .coreEnable(coreEnable), .sampleHold(sampleHold), .sarDac(sarDac));
    scc_core_model core (.sarDac(sarDac), .level(level),
        .compareIn(compareIn));

    task automatic step(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle strobe, as software writes and reads are
    task automatic pulse(ref logic s);
        s = 1'b1;
        step();
        s = 1'b0;
    endtask
    // bounded wait so a stuck conversion cannot hang the run
    task automatic waitIdle(output int len);
        len = 0;
        while (startConversion === 1'b1 && len < 300)
        begin
            step();
            len++;
        end
        if (len >= 300) errors++;
    endtask
    task automatic finish_test();
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog: the sequence needs well under 1000 cycles
    initial
    begin
        #(5 * 3000);
        errors++;
        finish_test();
    end

    // main sequence
    initial
    begin
        int lenA, lenB;
        step(2);
        rst_n = 1'b1;
        chk({startConversion, conversionCompleteFlag, gainBypass}, 16'h0001);
        selectWrite = 7'h23;
        level = 10'h2A5;
        step(2);
        chk(appliedSel, 16'h0000);
        converterEnable = 1'b1;
        step(2);
        chk({gainBypass, appliedSel}, 16'h00A3);
        pulse(startWrite);
        chk(startConversion, 16'h0001);
        waitIdle(lenA);
        step();
        chk(conversionCompleteFlag, 16'h0001);
        chk(resultBytes, 16'h02A5);
        leftAdjustResult = 1'b1;
        pulse(startWrite);
        waitIdle(lenB);
        chk(16'(lenA - lenB), 16'h000C);
        step();
        chk(resultBytes, 16'hA940);
        // lock, discard, unlock
        pulse(lowByteRead);
        pulse(flagClear);
        level = 10'h155;
        pulse(startWrite);
        waitIdle(lenA);
        step();
        chk(conversionCompleteFlag, 16'h0001);
        chk(resultBytes, 16'hA940);
        pulse(highByteRead);
        leftAdjustResult = 1'b0;
        pulse(startWrite);
        waitIdle(lenA);
        step();
        chk(resultBytes, 16'h0155);
        completionIrqEnable = 1'b1;
        step(2);
        chk(irqRequest, 16'h0000);
        globalIrqEnable = 1'b1;
        step(2);
        chk(irqRequest, 16'h0001);
        pulse(flagClear);
        step();
        chk(irqRequest, 16'h0000);
        // selection change during a differential conversion
        selectWrite = 7'h09;
        step();
        pulse(startWrite);
        step(3);
        selectWrite = 7'h22;
        step(2);
        chk({gainBypass, appliedSel}, 16'h0009);
        waitIdle(lenA);
        step(2);
        chk(appliedSel, 16'h0022);
        // auto trigger on source 3
        autoTriggerEnable = 1'b1;
        triggerSourceSelect = 3'h3;
        triggerIn = 8'h08;
        step(2);
        chk(startConversion, 16'h0001);
        triggerIn = 8'h00;
        step();
        triggerIn = 8'h08;
        waitIdle(lenA);
        step(3);
        chk(startConversion, 16'h0000);
        pulse(startWrite);
        chk(startConversion, 16'h0001);
        waitIdle(lenA);
        // free running from the completion flag
        pulse(flagClear);
        triggerSourceSelect = 3'h0;
        step(2);
        chk(startConversion, 16'h0000);
        pulse(startWrite);
        for (int i = 0; i < 100 && conversionCompleteFlag !== 1'b1; i++)
            step();
        step(3);
        chk(conversionCompleteFlag, 16'h0001);
        chk(startConversion, 16'h0001);
        converterEnable = 1'b0;
        step(2);
        chk({startConversion, coreEnable}, 16'h0000);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
